// File: hdl/art_timer.sv
// Sixteen-bit auto-reload down-counting timer with mask compare, capture and two output pins.
// Assumes an APB master on pclk, event inputs synchronous to pclk, and software writing high byte first.
//
// Function
// [R1] 16-bit down counter behind 1/4/16 prescaler.
// [R2] Run bit cleared holds counter at zero.
// [R3] Wrap without reload loads all ones.
// [R4] Wrap with reload loads reload register.
// [R5] Every wrap sets the wrap flag.
// [R6] Input events with reload enabled reload counter.
// [R7] Wrap interval is reload plus one ticks.
// [R8] Masked counter compared with zero and value.
// [R9] Masked matches set zero and compare flags.
// [R10] Masked matches recur at mask-derived period.
// [R11] Software programs only contiguous low masks.
// [R12] Reload register captures only without reload.
// [R13] Free run captures leave counter undisturbed.
// [R14] With reload, first event reloads, second captures.
// [R15] Disabled pulse pin follows polarity bit.
// [R16] Set/reset mode: zero match asserts pin.
// [R17] Set/reset mode: compare match deasserts pin.
// [R18] Toggle mode inverts pin on compare match.
// [R19] Set mode wrap pin cleared with flag.
// [R20] Toggle mode wrap pin inverts each wrap.
// [R21] Restart from software, input a or b.
// [R22] Input b strobes capture into capture register.
// [R23] Restart select codes choose start source.
// [R24] Prescale code zero stops only counting; events, flags and captures still act.
// [R25] Wrap flag cleared by software, never set.
// [R26] High byte staged, committed with low byte.
// [R27] Counter moves one step per tick only.
//
// The APB slave port and the address map were chosen for this implementation.
module art_timer
  import art_pkg::*;
(
  // Clock, reset and freeze.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // External event inputs.
  input  wire logic        event_input_a,
  input  wire logic        event_input_b,
  // Output pins.
  output art_pins_t        pins
);

  // Registers.
  logic [ART_C_WIDTH-1:0] ctrl_reg;            // Control bits.
  logic [ART_S_WIDTH-1:0] stat_reg;            // Sticky flags.
  logic [15:0]            reload_capture_reg;  // Reload or capture value.
  logic [15:0]            capture_reg;         // Capture value.
  logic [15:0]            compare_value_reg;   // Compare value.
  logic [15:0]            mask_reg;            // Compare mask.
  logic [7:0]             high_byte_reg;       // Staged high byte.
  logic [15:0]            down_count_value;    // The counter.
  logic [3:0]             psc_reg;             // Prescaler count.
  logic                   a_prev_reg;          // Input a last level.
  logic                   b_prev_reg;          // Input b last level.
  logic                   run_prev_reg;        // Run bit last value.
  logic                   started_reg;         // Counting enabled after restart.
  logic                   b_armed_reg;         // Reload seen, next b event captures.
  logic                   match_z_prev_reg;    // Last zero-match level.
  logic                   match_c_prev_reg;    // Last compare-match level.

  // Control fields.
  logic       run_hold_ctrl;
  logic       reload_en;
  logic [1:0] restart_sel;
  art_psc_t   psc_sel;
  assign run_hold_ctrl = ctrl_reg[ART_C_RUN];
  assign reload_en     = ctrl_reg[ART_C_RELOAD];
  assign restart_sel   = {ctrl_reg[ART_C_RSEL_HI], ctrl_reg[ART_C_RSEL_LO]};
  assign psc_sel       = art_psc_t'(ctrl_reg[ART_C_PSC_LO +: 2]);

  // Bus strobes; every access completes in its first access cycle.
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  assign wr_en = clk_en && psel && penable && pwrite;
  assign rd_en = clk_en && psel && penable && !pwrite;
  assign addr_ok = (paddr[7:5] == 3'b000) && (paddr[1:0] == 2'b00);

  // Full 16-bit write value: staged high byte joined with the written low byte.
  logic [15:0] wr_word;
  // [R26] Join staged byte.
  assign wr_word = {high_byte_reg, pwdata[7:0]};

  // Event detection on active edges of the inputs.
  logic a_evt;
  logic b_evt;
  assign a_evt = run_hold_ctrl && (event_input_a == ctrl_reg[ART_C_APOL]) && (a_prev_reg != ctrl_reg[ART_C_APOL]);
  assign b_evt = run_hold_ctrl && (event_input_b == ctrl_reg[ART_C_BPOL]) && (b_prev_reg != ctrl_reg[ART_C_BPOL]);

  // Restart trigger for the reload mode.
  logic sw_start;
  logic restart;
  assign sw_start = run_hold_ctrl && !run_prev_reg;
  // [R21] [R23] Start source select.
  always_comb begin
    restart = 1'b0;
    if (reload_en) begin
      case (restart_sel)
        ART_RS_SW: restart = sw_start;
        // [R6] Event reload.
        ART_RS_A:  restart = a_evt;
        ART_RS_B:  restart = b_evt;
        default:   restart = sw_start;
      endcase
    end
  end

  // Prescaler tick.
  logic tick;
  // [R1] [R24] Prescaler ratio.
  always_comb begin
    case (psc_sel)
      ART_PSC_1:  tick = 1'b1;
      ART_PSC_4:  tick = (psc_reg[1:0] == ART_DIV4_LAST[1:0]);
      ART_PSC_16: tick = (psc_reg == ART_DIV16_LAST);
      default:    tick = 1'b0;
    endcase
  end

  // Counting is allowed once running and, in reload mode, once started.
  logic count_ok;
  logic wrap;
  assign count_ok = run_hold_ctrl && (started_reg || !reload_en) && tick;
  assign wrap = count_ok && (down_count_value == ART_ZERO);

  // Masked comparisons; a match flags on the cycle its level first appears.
  logic zero_hit;
  logic cmp_hit;
  logic zero_rise;
  logic cmp_rise;
  logic [15:0] mask_eff;  // Mask actually applied to both comparisons.
  // [R10] Empty mask period.
  // An all-zero mask would match without a break and never edge; bit zero alone gives the two-tick period.
  assign mask_eff  = (mask_reg == ART_ZERO) ? 16'h0001 : mask_reg;
  // [R8] [R10] Masked compare.
  assign zero_hit  = run_hold_ctrl && ((down_count_value & mask_eff) == ART_ZERO);
  assign cmp_hit   = run_hold_ctrl && ((down_count_value & mask_eff) == (compare_value_reg & mask_eff));
  assign zero_rise = zero_hit && !match_z_prev_reg;
  assign cmp_rise  = cmp_hit && !match_c_prev_reg;

  // Capture decisions.
  logic cap_b;
  logic cap_a;
  // [R22] [R14] Input b captures; in reload mode only after a start.
  assign cap_b = b_evt && (!reload_en || started_reg);
  // [R12] [R13] Reload register captures only in free run.
  assign cap_a = a_evt && !reload_en;

  // Input history, used for edge detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_prev_reg   <= 1'b0;
      b_prev_reg   <= 1'b0;
      run_prev_reg <= 1'b0;
    end else if (clk_en) begin
      a_prev_reg   <= event_input_a;
      b_prev_reg   <= event_input_b;
      run_prev_reg <= run_hold_ctrl;
    end
  end

  // Prescaler; cleared whenever held or disabled so ratios start clean.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psc_reg <= 4'h0;
    end else if (clk_en) begin
      if (!run_hold_ctrl || psc_sel == ART_PSC_OFF) begin
        psc_reg <= 4'h0;
      end else begin
        psc_reg <= psc_reg + 4'h1;
      end
    end
  end

  // Start state and the second-event arming for reload mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      started_reg <= 1'b0;
      b_armed_reg <= 1'b0;
    end else if (clk_en) begin
      if (!run_hold_ctrl) begin
        started_reg <= 1'b0;
        b_armed_reg <= 1'b0;
      end else if (restart) begin
        started_reg <= 1'b1;
        b_armed_reg <= 1'b1;
      end
    end
  end

  // Counter. Capture reads the old value, so a simultaneous capture sees the count before reload.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      down_count_value <= ART_ZERO;
    end else if (clk_en) begin
      if (!run_hold_ctrl) begin
        // [R2] Hold at zero.
        down_count_value <= ART_ZERO;
      end else if (restart) begin
        // [R6] [R21] Restart reload.
        down_count_value <= reload_capture_reg;
      end else if (wrap) begin
        // [R3] [R4] [R7] Wrap reload.
        down_count_value <= reload_en ? reload_capture_reg : ART_ALL_ONES;
      end else if (count_ok) begin
        // [R27] One step per tick.
        down_count_value <= down_count_value - 16'h0001;
      end
    end
  end

  // Control, mask, compare and staging registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg          <= ART_CTRL_RESET;
      mask_reg          <= ART_MASK_RESET;
      compare_value_reg <= ART_ZERO;
      high_byte_reg     <= 8'h00;
    end else if (wr_en && addr_ok) begin
      case (paddr)
        ART_CTRL_OFS: ctrl_reg <= pwdata[ART_C_WIDTH-1:0];
        // [R26] Stage high byte.
        ART_HIGH_OFS: high_byte_reg <= pwdata[7:0];
        ART_CMP_OFS:  compare_value_reg <= wr_word;
        // [R11] Mask taken as written; contiguous values are up to software.
        ART_MASK_OFS: mask_reg <= wr_word;
        default:      high_byte_reg <= high_byte_reg;
      endcase
    end
  end

  // Reload and capture registers; software may write the reload value too.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_capture_reg <= ART_ZERO;
      capture_reg        <= ART_ZERO;
    end else if (clk_en) begin
      // [R12] Capture beats software write.
      if (cap_a) begin
        reload_capture_reg <= down_count_value;
      end else if (wr_en && paddr == ART_RELOAD_OFS) begin
        reload_capture_reg <= wr_word;
      end
      // [R22] Strobe capture.
      if (cap_b && (b_armed_reg || !reload_en)) begin
        capture_reg <= down_count_value;
      end
    end
  end

  // Status flags; a set in the same cycle as a clear wins.
  logic [ART_S_WIDTH-1:0] stat_set;
  logic [ART_S_WIDTH-1:0] stat_clr;
  always_comb begin
    stat_set = '0;
    // [R5] Wrap flag.
    stat_set[ART_S_WRAP] = wrap;
    // [R9] Match flags.
    stat_set[ART_S_ZERO] = zero_rise;
    stat_set[ART_S_CMP]  = cmp_rise;
    stat_set[ART_S_AEV]  = a_evt;
    stat_set[ART_S_BEV]  = b_evt;
    stat_clr = (wr_en && paddr == ART_STAT_OFS) ? pwdata[ART_S_WIDTH-1:0] : '0;
  end

  // One flag per bit: set by hardware only, cleared by writing one.
  genvar gi;
  generate
    for (gi = 0; gi < ART_S_WIDTH; gi++) begin : g_flag
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stat_reg[gi] <= 1'b0;
        end else if (clk_en) begin
          // [R25] Write clears only.
          stat_reg[gi] <= stat_set[gi] | (stat_reg[gi] & ~stat_clr[gi]);
        end
      end
    end
  endgenerate

  // Match level history.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_z_prev_reg <= 1'b0;
      match_c_prev_reg <= 1'b0;
    end else if (clk_en) begin
      match_z_prev_reg <= zero_hit;
      match_c_prev_reg <= cmp_hit;
    end
  end

  // Pulse-width pin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins.pulse <= 1'b0;
    end else if (clk_en) begin
      if (!ctrl_reg[ART_C_PEN]) begin
        // [R15] Static level.
        pins.pulse <= ctrl_reg[ART_C_PPOL];
      end else if (ctrl_reg[ART_C_PTOG]) begin
        // [R18] Toggle on compare.
        if (cmp_rise) begin
          pins.pulse <= ~pins.pulse;
        end
      end else if (zero_rise) begin
        // [R16] Zero match asserts.
        pins.pulse <= ctrl_reg[ART_C_PPOL];
      end else if (cmp_rise) begin
        // [R17] Compare deasserts.
        pins.pulse <= ~ctrl_reg[ART_C_PPOL];
      end
    end
  end

  // Wrap pin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins.wrap <= 1'b0;
    end else if (clk_en) begin
      if (ctrl_reg[ART_C_WRAPTG]) begin
        // [R20] Toggle each wrap.
        if (wrap) begin
          pins.wrap <= ~pins.wrap;
        end
      end else begin
        // [R19] Follows wrap flag.
        pins.wrap <= wrap | (stat_reg[ART_S_WRAP] & ~stat_clr[ART_S_WRAP]);
      end
    end
  end

  // Read mux; the answer is registered at the setup edge and given with pready in the first access cycle.
  logic [31:0] rd_word;
  always_comb begin
    case (paddr)
      ART_CTRL_OFS:   rd_word = {20'h00000, ctrl_reg};
      ART_STAT_OFS:   rd_word = {27'h0000000, stat_reg};
      ART_RELOAD_OFS: rd_word = {16'h0000, reload_capture_reg};
      ART_CAPT_OFS:   rd_word = {16'h0000, capture_reg};
      ART_CMP_OFS:    rd_word = {16'h0000, compare_value_reg};
      ART_MASK_OFS:   rd_word = {16'h0000, mask_reg};
      ART_COUNT_OFS:  rd_word = {16'h0000, down_count_value};
      ART_HIGH_OFS:   rd_word = {24'h000000, high_byte_reg};
      default:        rd_word = 32'h00000000;
    endcase
  end

  // Bus answer registers; pready and prdata load at the setup edge, so the answer comes in the first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable && !pwrite) begin
        prdata <= rd_word;
      end
    end
  end

endmodule

// File: hdl/art_pkg.sv
// Package for the sixteen-bit auto-reload timer: register map, field positions, reset values, mode codes.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package art_pkg;

  // Byte offsets of the registers.
  localparam logic [7:0] ART_CTRL_OFS    = 8'h00;  // Control bits.
  localparam logic [7:0] ART_STAT_OFS    = 8'h04;  // Sticky flags, write one to clear.
  localparam logic [7:0] ART_RELOAD_OFS  = 8'h08;  // Reload or capture-one register.
  localparam logic [7:0] ART_CAPT_OFS    = 8'h0c;  // Capture register.
  localparam logic [7:0] ART_CMP_OFS     = 8'h10;  // Compare value.
  localparam logic [7:0] ART_MASK_OFS    = 8'h14;  // Compare mask.
  localparam logic [7:0] ART_COUNT_OFS   = 8'h18;  // Counter, read only.
  localparam logic [7:0] ART_HIGH_OFS    = 8'h1c;  // High-byte staging register.

  // Control field positions.
  localparam int ART_C_PSC_LO  = 0;  // Two-bit prescale select, bits 1:0.
  localparam int ART_C_RELOAD  = 2;  // Reload enable.
  localparam int ART_C_RUN     = 3;  // Run or hold.
  localparam int ART_C_WRAPTG  = 4;  // Wrap output toggle select.
  localparam int ART_C_PEN     = 5;  // Pulse output enable.
  localparam int ART_C_PTOG    = 6;  // Pulse toggle select.
  localparam int ART_C_PPOL    = 7;  // Pulse polarity.
  localparam int ART_C_RSEL_LO = 8;  // Restart select low.
  localparam int ART_C_RSEL_HI = 9;  // Restart select high.
  localparam int ART_C_APOL    = 10; // Active level of input a.
  localparam int ART_C_BPOL    = 11; // Active level of input b.
  localparam int ART_C_WIDTH   = 12;

  // Status field positions.
  localparam int ART_S_WRAP = 0;
  localparam int ART_S_ZERO = 1;
  localparam int ART_S_CMP  = 2;
  localparam int ART_S_AEV  = 3;
  localparam int ART_S_BEV  = 4;
  localparam int ART_S_WIDTH = 5;

  // Reset values and the free-run wrap value.
  localparam logic [15:0] ART_ALL_ONES   = 16'hffff;
  localparam logic [15:0] ART_ZERO       = 16'h0000;
  localparam logic [15:0] ART_MASK_RESET = 16'hffff;
  localparam logic [ART_C_WIDTH-1:0] ART_CTRL_RESET = 12'h000;

  // Prescale division terminal counts, minus one.
  localparam logic [3:0] ART_DIV4_LAST  = 4'h3;
  localparam logic [3:0] ART_DIV16_LAST = 4'hf;

  // Prescale select codes.
  typedef enum logic [1:0] {ART_PSC_OFF, ART_PSC_1, ART_PSC_4, ART_PSC_16} art_psc_t;

  // Restart source codes, high bit then low bit.
  localparam logic [1:0] ART_RS_SW = 2'b00;
  localparam logic [1:0] ART_RS_A  = 2'b01;
  localparam logic [1:0] ART_RS_B  = 2'b10;

  // Output pins as one carrier.
  typedef struct packed {
    logic pulse;
    logic wrap;
  } art_pins_t;

endpackage

// File: verification/art_chk_asserts.sv
// Checker for the timer's bus handshake and the static behaviour of its two pins.
// Assumes it is bound to art_timer and sees only that module's ports.
module art_chk
  import art_pkg::*;
(
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  // Bus.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Events and pins.
  input wire logic        event_input_a,
  input wire logic        event_input_b,
  input wire art_pins_t   pins
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [ART_C_WIDTH-1:0] ctrl_reg;  // Shadow of the control register.
  logic                   wr_done;   // A write completes at this edge.

  assign wr_done = psel && penable && pwrite && pready && clk_en;

  // The shadow follows completed control writes, so pin checks know the mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= ART_CTRL_RESET;
    end else if (wr_done && paddr == ART_CTRL_OFS) begin
      ctrl_reg <= pwdata[ART_C_WIDTH-1:0];
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ready_after_setup;
    psel && !penable && clk_en |=> pready;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("pready late after setup");

  property p_ready_single;
    pready |=> !pready;
  endproperty
  a_ready_single: assert property (p_ready_single) else $error("pready longer than one cycle");

  property p_unmapped;
    pready && !pwrite && paddr >= 8'h20 |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");

  property p_mapped;
    pready && paddr < 8'h20 && paddr[1:0] == 2'b00 |-> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");

  // Two quiet cycles give the registered pin time to settle.
  property p_pulse_static;
    ($stable(ctrl_reg) && !ctrl_reg[ART_C_PEN]) [*2] |-> pins.pulse == ctrl_reg[ART_C_PPOL];
  endproperty
  a_pulse_static: assert property (p_pulse_static) else $error("idle pulse pin off polarity");

  property p_count_held;
    (!ctrl_reg[ART_C_RUN]) [*4] ##0 (pready && !pwrite && paddr == ART_COUNT_OFS) |-> prdata[15:0] == ART_ZERO;
  endproperty
  a_count_held: assert property (p_count_held) else $error("stopped counter not zero");

  // Run is low here, so no new wrap can race the clear.
  property p_wrap_clear;
    wr_done && paddr == ART_STAT_OFS && pwdata[ART_S_WRAP] && !ctrl_reg[ART_C_WRAPTG] && !ctrl_reg[ART_C_RUN]
      |-> ##[1:3] !pins.wrap;
  endproperty
  a_wrap_clear: assert property (p_wrap_clear) else $error("wrap pin stays after flag clear");

  property p_wrap_quiet;
    (ctrl_reg[ART_C_WRAPTG] && !ctrl_reg[ART_C_RUN] && $stable(ctrl_reg)) [*3] |-> $stable(pins.wrap);
  endproperty
  a_wrap_quiet: assert property (p_wrap_quiet) else $error("wrap pin toggles with no wrap");
endmodule

bind art_timer art_chk i_chk (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
                              .prdata, .pslverr, .event_input_a, .event_input_b, .pins);

// File: verification/art_evt_model.sv
// Model of the external event sources feeding the timer's restart and capture inputs.
// Assumes the bench calls strike from its own thread; lines idle low and are active high.
module art_evt_model (
  // Clock shared with the timer.
  input  wire logic pclk,
  // Event lines towards the timer.
  output logic      event_input_a,
  output logic      event_input_b
);
  timeunit 1ns;
  timeprecision 1ps;

  // Both lines start at their idle level.
  initial begin
    event_input_a = 1'b0;
    event_input_b = 1'b0;
  end

  // Raise one line for len cycles; a short len is a prompt source, a long one a slow one.
  task automatic strike(input logic on_b, input int len);
    @(posedge pclk);
    if (on_b) event_input_b <= 1'b1;
    else event_input_a <= 1'b1;
    repeat (len) @(posedge pclk);
    event_input_a <= 1'b0;
    event_input_b <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
endmodule

// File: verification/tb_top.sv
// Self-checking bench for the auto-reload timer through its bus, event inputs and pins.
// Assumes the package, the timer, the checker and the event model are compiled first.
module tb_top
  import art_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err, ev_a, ev_b;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  art_pins_t   pins;
  int          mismatches, n_checks;

  art_timer i_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
                   .prdata, .pslverr, .event_input_a(ev_a), .event_input_b(ev_b), .pins);
  art_evt_model i_evt (.pclk, .event_input_a(ev_a), .event_input_b(ev_b));

  // 10 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Every comparison is counted; a mismatch is reported at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic c);
    chk({31'h0, c}, 32'h1);
  endtask

  // One bus transfer; pready and the answer are taken at the rising edge, before that edge updates them.
  // No wait limit here: only the watchdog ends a transfer that never completes.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Sixteen-bit writes go high byte first.
  task automatic w16(input logic [7:0] a, input logic [15:0] v);
    apb(ART_HIGH_OFS, 1'b1, {24'h0, v[15:8]});
    apb(a, 1'b1, {24'h0, v[7:0]});
  endtask

  // Reads spaced three cycles apart; returns how far the counter fell over k gaps.
  task automatic cnt_gap(input int k, output logic [15:0] d);
    logic [15:0] f;
    apb(ART_COUNT_OFS, 1'b0, 32'h0);
    f = rd[15:0];
    repeat (k) apb(ART_COUNT_OFS, 1'b0, 32'h0);
    d = f - rd[15:0];
  endtask

  task automatic t_regs();
    apb(ART_MASK_OFS, 1'b0, 32'h0);
    chk(rd, 32'hffff);
    apb(ART_COUNT_OFS, 1'b1, 32'h55);
    apb(ART_COUNT_OFS, 1'b0, 32'h0);
    chk(rd, 32'h0);
    apb(8'h20, 1'b0, 32'h0);
    chk({31'h0, err}, 32'h1);
    w16(ART_CMP_OFS, 16'h1234);
    apb(ART_CMP_OFS, 1'b0, 32'h0);
    chk(rd, 32'h1234);
    apb(ART_CMP_OFS, 1'b1, 32'h56);
    apb(ART_CMP_OFS, 1'b0, 32'h0);
    chk(rd, 32'h1256);
    $display("test regs done");
  endtask

  task automatic t_rate();
    logic [15:0] d;
    apb(ART_CTRL_OFS, 1'b1, 32'h9);
    apb(ART_COUNT_OFS, 1'b0, 32'h0);
    chk({24'h0, rd[15:8]}, 32'hff);
    for (int c = 1; c < 4; c++) begin
      apb(ART_CTRL_OFS, 1'b1, 32'h8 | c);
      cnt_gap(1 << (2 * (c - 1)), d);
      chk({16'h0, d}, 32'h3);
      apb(ART_CTRL_OFS, 1'b1, 32'h8);
      cnt_gap(2, d);
      chk({16'h0, d}, 32'h0);
    end
    // Ten frozen cycles between two reads leave the usual three-step gap.
    apb(ART_CTRL_OFS, 1'b1, 32'h9);
    apb(ART_COUNT_OFS, 1'b0, 32'h0);
    d = rd[15:0];
    clk_en <= 1'b0;
    repeat (10) @(posedge pclk);
    clk_en <= 1'b1;
    apb(ART_COUNT_OFS, 1'b0, 32'h0);
    chk({16'h0, d - rd[15:0]}, 32'h3);
    apb(ART_STAT_OFS, 1'b0, 32'h0);
    chkb(rd[ART_S_WRAP]);
    apb(ART_CTRL_OFS, 1'b1, 32'h0);
    apb(ART_STAT_OFS, 1'b1, 32'h1f);
    apb(ART_STAT_OFS, 1'b1, 32'h1f);
    apb(ART_STAT_OFS, 1'b0, 32'h0);
    chk(rd, 32'h0);
    $display("test rate done");
  endtask

  task automatic t_reload();
    logic [15:0] d;
    w16(ART_RELOAD_OFS, 16'h0009);
    apb(ART_CTRL_OFS, 1'b1, 32'hd);
    apb(ART_COUNT_OFS, 1'b0, 32'h0);
    chkb(rd[15:0] <= 16'h9);
    cnt_gap(10, d);
    chk({16'h0, d}, 32'h0);
    apb(ART_CTRL_OFS, 1'b1, 32'h0);
    w16(ART_RELOAD_OFS, 16'h4000);
    for (int s = 1; s < 3; s++) begin
      apb(ART_CTRL_OFS, 1'b1, 32'hc0d | (s << 8));
      apb(ART_COUNT_OFS, 1'b0, 32'h0);
      chk(rd, 32'h0);
      i_evt.strike(s == 2, 2);
      apb(ART_COUNT_OFS, 1'b0, 32'h0);
      chkb(rd[15:0] > 16'h3fe0 && rd[15:0] <= 16'h4000);
      i_evt.strike(1'b1, 4);
      apb(ART_CAPT_OFS, 1'b0, 32'h0);
      chk({24'h0, rd[15:8]}, 32'h3f);
      apb(ART_RELOAD_OFS, 1'b0, 32'h0);
      chk(rd, 32'h4000);
      apb(ART_CTRL_OFS, 1'b1, 32'h0);
    end
    $display("test reload done");
  endtask

  task automatic t_cap();
    logic [15:0] r;
    logic [15:0] c;
    apb(ART_CTRL_OFS, 1'b1, 32'hc09);
    i_evt.strike(1'b0, 1);
    i_evt.strike(1'b1, 1);
    apb(ART_RELOAD_OFS, 1'b0, 32'h0);
    r = rd[15:0];
    apb(ART_CAPT_OFS, 1'b0, 32'h0);
    c = rd[15:0];
    apb(ART_COUNT_OFS, 1'b0, 32'h0);
    chk({24'h0, r[15:8]}, 32'hff);
    chkb(c < r && rd[15:0] < c);
    apb(ART_CTRL_OFS, 1'b1, 32'h0);
    $display("test capture done");
  endtask

  // Counts how many of 16 cycles each pin spends high.
  task automatic count_hi(output int hp, output int hw);
    hp = 0;
    hw = 0;
    repeat (16) begin
      @(negedge pclk);
      hp += (pins.pulse === 1'b1);
      hw += (pins.wrap === 1'b1);
    end
  endtask

  task automatic t_pins();
    int hp;
    int hw;
    apb(ART_CTRL_OFS, 1'b1, 32'h80);
    repeat (2) @(negedge pclk);
    chkb(pins.pulse);
    w16(ART_MASK_OFS, 16'h0003);
    w16(ART_CMP_OFS, 16'h0001);
    w16(ART_RELOAD_OFS, 16'h0003);
    apb(ART_CTRL_OFS, 1'b1, 32'had);
    repeat (8) @(negedge pclk);
    count_hi(hp, hw);
    chk(hp, 32'hc);
    apb(ART_STAT_OFS, 1'b0, 32'h0);
    chk({30'h0, rd[ART_S_CMP:ART_S_ZERO]}, 32'h3);
    apb(ART_CTRL_OFS, 1'b1, 32'hfd);
    repeat (8) @(negedge pclk);
    count_hi(hp, hw);
    chk(hp, 32'h8);
    chk(hw, 32'h8);
    apb(ART_CTRL_OFS, 1'b1, 32'h10);
    // Clear the flag while stopped, so only a fresh wrap can raise the pin.
    apb(ART_STAT_OFS, 1'b1, 32'h1);
    apb(ART_CTRL_OFS, 1'b1, 32'hd);
    repeat (8) @(negedge pclk);
    chkb(pins.wrap);
    apb(ART_CTRL_OFS, 1'b1, 32'h0);
    apb(ART_STAT_OFS, 1'b1, 32'h1);
    repeat (3) @(negedge pclk);
    chk({31'h0, pins.wrap}, 32'h0);
    $display("test pins done");
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // A hang counts as a mismatch and ends the run the normal way.
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    mismatches = 0;
    n_checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_rate();
    t_reload();
    t_cap();
    t_pins();
    tally_and_finish();
  end
endmodule
